/* File: include/bowe_cfg.svh */
// constants for the bitmap overlay window engine
`ifndef BOWE_CFG_SVH
`define BOWE_CFG_SVH
// window set
`define BOWE_NWIN 4'h9
`define BOWE_CPLX 4'h0
`define BOWE_LUT_N 10'h200
// window register block region and word offsets
`define BOWE_RGN_WIN 3'h2
`define BOWE_W_CTRL 3'h0
`define BOWE_W_POS 3'h1
`define BOWE_W_SIZE 3'h2
`define BOWE_W_BADR 3'h3
`define BOWE_W_BUFR 3'h4
// global register byte addresses
`define BOWE_A_GCTRL 12'h000
`define BOWE_A_RLE 12'h004
`define BOWE_A_LIDX 12'h008
`define BOWE_A_LDAT 12'h00C
`define BOWE_A_CBUF 12'h010
`define BOWE_A_CIMG 12'h014
`define BOWE_A_LOOP 12'h018
`define BOWE_A_STAT 12'h01C
`define BOWE_A_FADR 12'h020
// pixel depth codes and field widths
`define BOWE_DEP_4 2'h0
`define BOWE_DEP_6 2'h1
`define BOWE_BITS_4 5'h04
`define BOWE_BITS_6 5'h06
`define BOWE_BITS_8 5'h08
`define BOWE_REP_MIN 5'h02
`define BOWE_REP_MAX 5'h10
// full overlay weight
`define BOWE_A_FULL 8'h80
`endif

/* File: include/bowe_pkg.sv */
// types for the bitmap overlay window engine
`default_nettype none
`include "bowe_cfg.svh"
package bowe_pkg;
	typedef enum logic [3:0] {
		DEC_TYPE = 4'b0001,
		DEC_DATA = 4'b0010,
		DEC_REP = 4'b0100,
		DEC_RPT = 4'b1000
	} bowe_dec_t;
	typedef struct packed {logic [2:0] rgn; logic [3:0] win; logic [2:0] off; logic [1:0] lane;} bowe_addr_t;
	typedef struct packed {logic [11:0] x; logic [11:0] y; logic [23:0] rgb;} bowe_pos_t;
	typedef struct packed {logic [23:0] rgb; logic [6:0] alpha; logic blink;} bowe_lut_t;
	typedef struct packed {logic [22:0] rsv; logic [6:0] alpha; logic blend_win; logic en;} bowe_wctrl_t;
	typedef struct packed {logic [3:0] r1; logic [11:0] y; logic [3:0] r0; logic [11:0] x;} bowe_xy_t;
	typedef struct packed {logic [6:0] r1; logic [8:0] lut_off; logic [3:0] r0; logic [11:0] bhlen;} bowe_bufr_t;
	typedef struct packed {
		logic [14:0] rsv;
		logic blink_phase;
		logic [3:0] strm_win;
		logic rle_en;
		logic [3:0] rle_win;
		logic [4:0] rsv0;
		logic [1:0] depth;
	} bowe_gctrl_t;
	typedef struct packed {logic [21:0] rsv; logic [4:0] rep_w; logic [4:0] dat_w;} bowe_rlectl_t;
	typedef struct packed {logic [15:0] dur; logic [3:0] r1; logic [3:0] m; logic [3:0] r0; logic [3:0] n;} bowe_loop_t;
	typedef struct packed {logic [15:0] rsv; logic [3:0] fy; logic [3:0] fx; bowe_dec_t dec; logic [3:0] flags;} bowe_stat_t;
	typedef struct packed {
		bowe_wctrl_t ctrl;
		bowe_xy_t pos;
		bowe_xy_t size;
		logic [23:0] baddr;
		bowe_bufr_t bufr;
	} bowe_win_t;
	typedef struct packed {
		logic [1:0] sck;
		logic [1:0] sdat;
		logic [1:0] csn;
		logic sck_d;
		bowe_dec_t dec;
		logic [15:0] acc;
		logic [4:0] nb;
		logic [7:0] last;
		logic [15:0] rpt;
		logic push;
		logic [7:0] code;
		bowe_gctrl_t g;
		bowe_rlectl_t rc;
		logic [8:0] lidx;
		bowe_xy_t cbuf;
		bowe_xy_t cimg;
		bowe_loop_t lp;
		logic [15:0] dur_tick;
		logic [3:0] fx;
		logic [3:0] fy;
		logic [23:0] fadr;
		bowe_win_t [`BOWE_NWIN-1:0] w;
		logic [31:0] prdata;
		logic ovalid;
		logic [23:0] orgb;
	} bowe_st_t;
endpackage : bowe_pkg
`default_nettype wire

/* File: hdl/bowe_buf.sv */
// two-entry valid/ready buffer for decoded pixel codes
`default_nettype none
module bowe_buf #(
	parameter int W = 8,
	parameter int D = 2
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// fill side
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	// drain side
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(D);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] rd;
		logic [AW-1:0] wr;
		logic [AW:0] fill;
	} bowe_fifo_st_t;
	bowe_fifo_st_t s_q, s_d;
	logic push, pop;

	assign in_ready = s_q.fill != (AW+1)'(D);
	assign out_valid = s_q.fill != '0;
	assign out_data = s_q.mem[s_q.rd];

	// ============================================================
	// pointers and fill level
	always_comb begin
		s_d = s_q;
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		if (push) begin
			s_d.mem[s_q.wr] = in_data;
			s_d.wr = AW'(s_q.wr + 1'b1);
		end
		if (pop) begin
			s_d.rd = AW'(s_q.rd + 1'b1);
		end
		s_d.fill = (AW+1)'(s_q.fill + (AW+1)'(push) - (AW+1)'(pop));
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule : bowe_buf
`default_nettype wire

/* File: hdl/bowe_top.sv */
// bitmap overlay window engine: registers, stream decoder, colour table, mixer
//
// Summary of operation
// - nine windows, window 0 complex, others simple
// - simple window buffer matches its display size
// - pixel codes of 4, 6 or 8 bits
// - table gives rgb24, alpha7, blink1 per code
// - mix with video, per-pixel or per-window alpha
// - run-length decoding on one simple window only
// - own registers, shared 512 table, code offset
// - any windows may overlap, lowest index wins, never blended together
// - start and length set placement per window
// - buffer address and lengths define source buffer
// - image start selects origin in complex buffer
// - frames loop row by row, then repeat
// - each frame held for programmed duration
// - first pixel in least significant bits
// - type bit: 0 data, 1 repeat count
// - data width 4/6/8, count width 2..16
`default_nettype none
`include "bowe_cfg.svh"
module bowe_top (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial flash pixel stream
	input wire logic lnk_sck,
	input wire logic lnk_sdat,
	input wire logic lnk_csn,
	output logic link_hold,
	// panel side
	input wire logic pos_valid,
	input wire bowe_pkg::bowe_pos_t pos,
	input wire logic frame_start,
	output logic pos_ready,
	output logic out_valid,
	output logic [23:0] out_rgb,
	// complex window frame fetch address
	output logic [23:0] fetch_addr
);
	import bowe_pkg::*;

	bowe_st_t s_q, s_d;
	bowe_lut_t lut_mem [`BOWE_LUT_N];
	bowe_addr_t a;
	logic buf_in_ready, buf_out_valid, buf_out_ready;
	logic [7:0] buf_out_code;
	logic acc_ph, set_ph, wr_en, mapped;
	logic bit_stb, bit_v, rle_mode, fld_done, dec_ok;
	logic [4:0] fld_w;
	logic [15:0] acc_n;
	logic [15:0] row;
	logic [15:0] col;
	logic hit, accept;
	logic [3:0] hw;
	logic [6:0] alpha;
	bowe_lut_t ent;
	bowe_win_t cw;
	bowe_bufr_t br;
	logic [31:0] rval;

	// ============================================================
	// helpers
	function automatic logic [4:0] depth_bits(input logic [1:0] sel);
		case (sel)
			`BOWE_DEP_4: depth_bits = `BOWE_BITS_4;
			`BOWE_DEP_6: depth_bits = `BOWE_BITS_6;
			default: depth_bits = `BOWE_BITS_8;
		endcase
	endfunction : depth_bits

	function automatic logic win_hit(input bowe_win_t w, input logic [11:0] x,
		input logic [11:0] y);
		win_hit = w.ctrl.en && (x >= w.pos.x) && (y >= w.pos.y)
			&& (13'(x) < 13'(w.pos.x) + 13'(w.size.x))
			&& (13'(y) < 13'(w.pos.y) + 13'(w.size.y));
	endfunction : win_hit

	function automatic logic [7:0] mix(input logic [7:0] ov, input logic [7:0] vd,
		input logic [6:0] wt);
		logic [15:0] t;
		t = 16'(16'(ov) * 16'(wt) + 16'(vd) * (16'(`BOWE_A_FULL) - 16'(wt)));
		mix = t[14:7];
	endfunction : mix

	function automatic bowe_xy_t xy_w(input logic [31:0] d);
		xy_w = bowe_xy_t'(d);
		xy_w.r0 = '0;
		xy_w.r1 = '0;
	endfunction : xy_w

	// ============================================================
	// apb decode
	assign a = bowe_addr_t'(paddr);
	assign acc_ph = psel && penable;
	assign set_ph = psel && !penable;
	assign wr_en = acc_ph && pwrite && mapped;
	assign pready = 1'b1;
	assign pslverr = acc_ph && !mapped;
	assign prdata = s_q.prdata;
	assign out_valid = s_q.ovalid;
	assign out_rgb = s_q.orgb;
	assign fetch_addr = s_q.fadr;
	assign link_hold = (s_q.dec == DEC_RPT) || s_q.push || !buf_in_ready;

	always_comb begin
		mapped = 1'b0;
		if (a.rgn == `BOWE_RGN_WIN) begin
			mapped = (a.win < `BOWE_NWIN) && (a.off <= `BOWE_W_BUFR);
		end else begin
			case (paddr)
				`BOWE_A_GCTRL, `BOWE_A_RLE, `BOWE_A_LIDX, `BOWE_A_LDAT,
				`BOWE_A_CBUF, `BOWE_A_CIMG, `BOWE_A_LOOP, `BOWE_A_STAT,
				`BOWE_A_FADR: mapped = 1'b1;
				default: mapped = 1'b0;
			endcase
		end
	end

	// ============================================================
	// register readback
	always_comb begin
		rval = '0;
		cw = s_q.w[`BOWE_CPLX];
		br = cw.bufr;
		if (mapped && a.rgn == `BOWE_RGN_WIN) begin
			cw = s_q.w[a.win];
			br = cw.bufr;
			if (a.win != `BOWE_CPLX) begin
				br.bhlen = cw.size.x;
			end
			case (a.off)
				`BOWE_W_CTRL: rval = cw.ctrl;
				`BOWE_W_POS: rval = cw.pos;
				`BOWE_W_SIZE: rval = cw.size;
				`BOWE_W_BADR: rval = 32'(cw.baddr);
				default: rval = br;
			endcase
		end else if (mapped) begin
			case (paddr)
				`BOWE_A_GCTRL: rval = s_q.g;
				`BOWE_A_RLE: rval = s_q.rc;
				`BOWE_A_LIDX: rval = 32'(s_q.lidx);
				`BOWE_A_LDAT: rval = lut_mem[s_q.lidx];
				`BOWE_A_CBUF: rval = s_q.cbuf;
				`BOWE_A_CIMG: rval = s_q.cimg;
				`BOWE_A_LOOP: rval = s_q.lp;
				`BOWE_A_STAT: rval = bowe_stat_t'({16'h0000, s_q.fy, s_q.fx, s_q.dec,
					link_hold, s_q.push, buf_out_valid, buf_in_ready});
				default: rval = 32'(s_q.fadr);
			endcase
		end
	end

	// ============================================================
	// colour table, written through the data port
	always_ff @(posedge pclk) begin
		if (wr_en && paddr == `BOWE_A_LDAT) begin
			lut_mem[s_q.lidx] <= bowe_lut_t'(pwdata);
		end
	end

	// ============================================================
	// next state
	always_comb begin
		s_d = s_q;
		// apb
		if (set_ph && !pwrite) begin
			s_d.prdata = rval;
		end
		if (wr_en && a.rgn == `BOWE_RGN_WIN) begin
			case (a.off)
				`BOWE_W_CTRL: begin
					s_d.w[a.win].ctrl = bowe_wctrl_t'(pwdata);
					s_d.w[a.win].ctrl.rsv = '0;
				end
				`BOWE_W_POS: s_d.w[a.win].pos = xy_w(pwdata);
				`BOWE_W_SIZE: s_d.w[a.win].size = xy_w(pwdata);
				`BOWE_W_BADR: s_d.w[a.win].baddr = pwdata[23:0];
				default: begin
					s_d.w[a.win].bufr = bowe_bufr_t'(pwdata);
					s_d.w[a.win].bufr.r0 = '0;
					s_d.w[a.win].bufr.r1 = '0;
				end
			endcase
		end else if (wr_en) begin
			case (paddr)
				`BOWE_A_GCTRL: begin
					s_d.g = bowe_gctrl_t'(pwdata);
					s_d.g.rsv = '0;
					s_d.g.rsv0 = '0;
				end
				`BOWE_A_RLE: begin
					s_d.rc = bowe_rlectl_t'(pwdata);
					s_d.rc.rsv = '0;
					if (s_d.rc.dat_w != `BOWE_BITS_4 && s_d.rc.dat_w != `BOWE_BITS_6) begin
						s_d.rc.dat_w = `BOWE_BITS_8;
					end
					if (s_d.rc.rep_w < `BOWE_REP_MIN) begin
						s_d.rc.rep_w = `BOWE_REP_MIN;
					end
					if (s_d.rc.rep_w > `BOWE_REP_MAX) begin
						s_d.rc.rep_w = `BOWE_REP_MAX;
					end
				end
				`BOWE_A_LIDX: s_d.lidx = pwdata[8:0];
				`BOWE_A_LDAT: s_d.lidx = 9'(s_q.lidx + 9'h001);
				`BOWE_A_CBUF: s_d.cbuf = xy_w(pwdata);
				`BOWE_A_CIMG: s_d.cimg = xy_w(pwdata);
				`BOWE_A_LOOP: begin
					s_d.lp = bowe_loop_t'(pwdata);
					s_d.lp.r0 = '0;
					s_d.lp.r1 = '0;
					s_d.fx = '0;
					s_d.fy = '0;
					s_d.dur_tick = '0;
				end
				default: s_d.lidx = s_q.lidx;
			endcase
		end

		// link sampling, two flops each
		s_d.sck = {s_q.sck[0], lnk_sck};
		s_d.sdat = {s_q.sdat[0], lnk_sdat};
		s_d.csn = {s_q.csn[0], lnk_csn};
		s_d.sck_d = s_q.sck[1];
		bit_stb = s_q.sck[1] && !s_q.sck_d && !s_q.csn[1];
		bit_v = s_q.sdat[1];

		// stream decoder
		rle_mode = s_q.g.rle_en && (s_q.g.strm_win == s_q.g.rle_win)
			&& (s_q.g.rle_win != `BOWE_CPLX) && (s_q.g.rle_win < `BOWE_NWIN);
		if (s_q.dec == DEC_REP) begin
			fld_w = s_q.rc.rep_w;
		end else if (rle_mode) begin
			fld_w = s_q.rc.dat_w;
		end else begin
			fld_w = depth_bits(s_q.g.depth);
		end
		acc_n = bit_v ? (s_q.acc | (16'h0001 << s_q.nb)) : s_q.acc;
		fld_done = 5'(s_q.nb + 5'h01) >= fld_w;
		dec_ok = !s_q.push && buf_in_ready;
		s_d.push = 1'b0;
		if (s_q.csn[1]) begin
			s_d.dec = rle_mode ? DEC_TYPE : DEC_DATA;
			s_d.nb = '0;
			s_d.acc = '0;
			s_d.rpt = '0;
		end else begin
			case (s_q.dec)
				DEC_TYPE: if (bit_stb) begin
					s_d.dec = bit_v ? DEC_REP : DEC_DATA;
					s_d.nb = '0;
					s_d.acc = '0;
				end
				DEC_DATA, DEC_REP: if (bit_stb) begin
					s_d.acc = acc_n;
					s_d.nb = 5'(s_q.nb + 5'h01);
					if (fld_done) begin
						s_d.nb = '0;
						s_d.acc = '0;
						if (s_q.dec == DEC_DATA) begin
							s_d.push = 1'b1;
							s_d.code = acc_n[7:0];
							s_d.last = acc_n[7:0];
							s_d.dec = rle_mode ? DEC_TYPE : DEC_DATA;
						end else begin
							s_d.rpt = acc_n;
							s_d.dec = (acc_n == '0) ? DEC_TYPE : DEC_RPT;
						end
					end
				end
				DEC_RPT: if (dec_ok) begin
					s_d.push = 1'b1;
					s_d.code = s_q.last;
					s_d.rpt = 16'(s_q.rpt - 16'h0001);
					if (s_q.rpt == 16'h0001) begin
						s_d.dec = DEC_TYPE;
					end
				end
				default: s_d.dec = DEC_TYPE;
			endcase
		end

		// complex window frame looping
		if (frame_start && s_q.lp.dur != '0) begin
			if (16'(s_q.dur_tick + 16'h0001) >= s_q.lp.dur) begin
				s_d.dur_tick = '0;
				if (s_q.fx >= s_q.lp.n) begin
					s_d.fx = '0;
					s_d.fy = (s_q.fy >= s_q.lp.m) ? 4'h0 : 4'(s_q.fy + 4'h1);
				end else begin
					s_d.fx = 4'(s_q.fx + 4'h1);
				end
			end else begin
				s_d.dur_tick = 16'(s_q.dur_tick + 16'h0001);
			end
		end
		row = 16'(16'(s_q.cimg.y) + 16'(s_q.fy) * 16'(s_q.w[`BOWE_CPLX].size.y));
		col = 16'(16'(s_q.cimg.x) + 16'(s_q.fx) * 16'(s_q.w[`BOWE_CPLX].size.x));
		s_d.fadr = 24'(s_q.w[`BOWE_CPLX].baddr
			+ 24'(row) * 24'(s_q.w[`BOWE_CPLX].bufr.bhlen) + 24'(col));

		// window select and mixing
		hit = 1'b0;
		hw = `BOWE_CPLX;
		for (int i = `BOWE_NWIN - 1; i >= 0; i--) begin
			if (win_hit(s_q.w[i], pos.x, pos.y)) begin
				hit = 1'b1;
				hw = 4'(i);
			end
		end
		pos_ready = !hit || buf_out_valid;
		accept = pos_valid && pos_ready;
		buf_out_ready = accept && hit;
		ent = lut_mem[9'(9'(buf_out_code) + s_q.w[hw].bufr.lut_off)];
		alpha = s_q.w[hw].ctrl.blend_win ? s_q.w[hw].ctrl.alpha : ent.alpha;
		s_d.ovalid = accept;
		if (accept) begin
			if (!hit || (ent.blink && s_q.g.blink_phase)) begin
				s_d.orgb = pos.rgb;
			end else begin
				s_d.orgb = {mix(ent.rgb[23:16], pos.rgb[23:16], alpha),
					mix(ent.rgb[15:8], pos.rgb[15:8], alpha),
					mix(ent.rgb[7:0], pos.rgb[7:0], alpha)};
			end
		end
	end

	// ============================================================
	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.csn <= '1;
			s_q.dec <= DEC_DATA;
			s_q.rc.dat_w <= `BOWE_BITS_8;
			s_q.rc.rep_w <= `BOWE_BITS_8;
		end else begin
			s_q <= s_d;
		end
	end

	// ============================================================
	// pixel code buffer
	bowe_buf #(
		.W(8),
		.D(2)
	) u_buf (
		.clk(pclk),
		.rst_n(presetn),
		.in_valid(s_q.push),
		.in_data(s_q.code),
		.in_ready(buf_in_ready),
		.out_valid(buf_out_valid),
		.out_data(buf_out_code),
		.out_ready(buf_out_ready)
	);
endmodule : bowe_top
`default_nettype wire

/* File: tb/bowe_checker.sv */
// port assertions for the overlay engine
`default_nettype none
module bowe_checker (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// panel and fetch
	input wire logic pos_valid,
	input wire logic pos_ready,
	input wire logic frame_start,
	input wire logic out_valid,
	input wire logic [23:0] out_rgb,
	input wire logic [23:0] fetch_addr
);
	timeunit 1ns;
	timeprecision 100ps;
	logic acc;
	logic cause;
	logic hit;
	assign acc = psel && penable;
	assign cause = frame_start || (acc && pwrite);
	assign hit = paddr <= 12'h020 || (paddr >= 12'h400 && paddr < 12'h520 && paddr[4:0] <= 5'h10);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ====
	// bus
	property p_ready;
		pready;
	endproperty
	a_ready: assert property (p_ready) else $error("pready low");
	property p_map;
		acc && paddr[1:0] == 2'h0 |-> pslverr == !hit;
	endproperty
	a_map: assert property (p_map) else $error("slave error wrong");
	property p_idle;
		!acc |-> !pslverr;
	endproperty
	a_idle: assert property (p_idle) else $error("slave error outside access");
	property p_rdata;
		$changed(prdata) |-> $past(psel && !penable && !pwrite);
	endproperty
	a_rdata: assert property (p_rdata) else $error("read data moved");
	// ====
	// panel
	property p_acc;
		pos_valid && pos_ready |=> out_valid;
	endproperty
	a_acc: assert property (p_acc) else $error("accepted position gave no pixel");
	property p_only;
		out_valid |-> $past(pos_valid && pos_ready);
	endproperty
	a_only: assert property (p_only) else $error("pixel without position");
	property p_hold;
		$changed(out_rgb) |-> out_valid;
	endproperty
	a_hold: assert property (p_hold) else $error("pixel moved between accepts");
	property p_fetch;
		$changed(fetch_addr) |-> $past(cause) || $past(cause, 2) || $past(cause, 3);
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch address moved alone");
endmodule : bowe_checker
bind bowe_top bowe_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .pos_valid(pos_valid), .pos_ready(pos_ready),
	.frame_start(frame_start), .out_valid(out_valid), .out_rgb(out_rgb),
	.fetch_addr(fetch_addr));
`default_nettype wire

/* File: tb/bowe_flash.sv */
// serial flash stream source model
`default_nettype none
module bowe_flash (
	// hold from the block
	input wire logic link_hold,
	// stream lines
	output logic lnk_sck,
	output logic lnk_sdat,
	output logic lnk_csn
);
	timeunit 1ns;
	timeprecision 100ps;
	int slow = 0;
	initial begin
		lnk_sck = 1'b0;
		lnk_sdat = 1'b1;
		lnk_csn = 1'b1;
	end
	// ====
	// frame of n bits, bit 0 first
	task automatic send(input logic [31:0] bits, input int n);
		int w;
		lnk_csn = 1'b0;
		#64;
		for (int i = 0; i < n; i++) begin
			lnk_sdat = bits[i];
			#(32 + slow);
			w = 0;
			while (link_hold !== 1'b0 && w < 4000) begin
				#8;
				w++;
			end
			lnk_sck = 1'b1;
			#32;
			lnk_sck = 1'b0;
		end
		#32;
		lnk_sdat = ~lnk_sdat;
		lnk_csn = 1'b1;
		#64;
	endtask : send
endmodule : bowe_flash
`default_nettype wire

/* File: tb/bowe_top_tb.sv */
// self-checking bench for the overlay engine
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module bowe_top_tb import bowe_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] x; logic err;} bowe_rrow_t;
	typedef struct {logic [11:0] x; logic [23:0] v; logic [23:0] o;} bowe_prow_t;
	logic pclk, presetn, psel, penable, pwrite, pslverr, pready, frame_start, e;
	logic lnk_sck, lnk_sdat, lnk_csn, link_hold, pos_valid, pos_ready, out_valid;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [23:0] out_rgb, fetch_addr;
	bowe_pos_t pos;
	int num_errors, samples_checked, cyc, f;
	bowe_rrow_t rr[9] = '{'{12'h020, 32'hFFFF_FFFF, 32'h0, 1'b0},
		'{12'h420, 32'hFFFF_FFFF, 32'h0000_01FF, 1'b0},
		'{12'h014, 32'hFFFF_FFFF, 32'h0FFF_0FFF, 1'b0},
		'{12'h004, 32'h0000_0085, 32'h0000_0088, 1'b0},
		'{12'h004, 32'h0000_0224, 32'h0000_0204, 1'b0},
		'{12'h004, 32'h0000_0026, 32'h0000_0046, 1'b0},
		'{12'h50C, 32'hFFFF_FFFF, 32'h00FF_FFFF, 1'b0},
		'{12'h520, 32'hFFFF_FFFF, 32'h0, 1'b1}, '{12'h024, 32'h1, 32'h0, 1'b1}};
	bowe_prow_t pr[6] = '{'{12'h010, 24'h00_0000, 24'h7F_4020},
		'{12'h030, 24'h12_3456, 24'h12_3456}, '{12'h011, 24'h00_0000, 24'h20_1008},
		'{12'h014, 24'h12_3456, 24'h12_3456}, '{12'h012, 24'h00_0000, 24'h01_0101},
		'{12'h013, 24'h00_0000, 24'h20_1008}};
	bowe_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .lnk_sck(lnk_sck), .lnk_sdat(lnk_sdat), .lnk_csn(lnk_csn),
		.link_hold(link_hold), .pos_valid(pos_valid), .pos(pos), .frame_start(frame_start),
		.pos_ready(pos_ready), .out_valid(out_valid), .out_rgb(out_rgb),
		.fetch_addr(fetch_addr));
	bowe_flash flash (.link_hold(link_hold), .lnk_sck(lnk_sck), .lnk_sdat(lnk_sdat),
		.lnk_csn(lnk_csn));
	// ====
	// bus and panel tasks
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		if (pready !== 1'b1) num_errors++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic cfg(input logic [43:0] q[$]);
		foreach (q[i]) apb(1'b1, q[i][43:32], q[i][31:0]);
	endtask : cfg
	task automatic show(input logic [11:0] x, input logic [23:0] v, input logic [23:0] o);
		int n;
		@(posedge pclk);
		pos_valid <= 1'b1;
		pos <= '{x: x, y: 12'h005, rgb: v};
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pos_ready !== 1'b1 && n < 3000);
		if (pos_ready !== 1'b1) num_errors++;
		pos_valid <= 1'b0;
		#1;
		`CHK(out_valid, 1'b1)
		`CHK(out_rgb, o)
	endtask : show
	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_sim
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 30000) begin
			num_errors++;
			end_sim();
		end
	end
	// ====
	// tests
	initial begin
		{presetn, psel, penable, pwrite, pos_valid, frame_start} = '0;
		paddr = '0;
		pwdata = '0;
		pos = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rr[i]) begin
			apb(1'b1, rr[i].a, rr[i].d);
			`CHK(e, rr[i].err)
			apb(1'b0, rr[i].a, 32'h0);
			`CHK(r, rr[i].x)
		end
		$display("register test done");
		cfg('{44'h000_0000_1002, 44'h424_0005_0010, 44'h428_0001_0004, 44'h430_0010_0000,
			44'h420_0000_0103, 44'h008_0000_0013, 44'h00C_FF80_4000, 44'h00C_4020_1000,
			44'h00C_0202_0200});
		fork
			flash.send(32'h0405_0403, 32);
			foreach (pr[i]) show(pr[i].x, pr[i].v, pr[i].o);
		join
		$display("window test done");
		cfg('{44'h000_0000_1000, 44'h420_0000_0001, 44'h008_0000_0011, 44'h00C_2040_6080,
			44'h00C_8080_8000});
		fork
			flash.send(32'h0000_0021, 8);
			begin
				show(12'h010, 24'h00_0000, 24'h10_2030);
				show(12'h011, 24'h12_3456, 24'h12_3456);
			end
		join
		$display("pixel order test done");
		cfg('{44'h004_0000_0088, 44'h000_0000_1882, 44'h420_0000_0103});
		flash.slow = 150;
		fork
			flash.send(32'h0002_0A0A, 23);
			for (int k = 0; k < 4; k++) begin
				show(12'h010 + 12'(k), 24'h0, k < 3 ? 24'h01_0101 : 24'h20_1008);
			end
		join
		$display("run length test done");
		cfg('{44'h000_0001_1001, 44'h008_0000_0014, 44'h00C_4020_1001});
		fork
			flash.send(32'h0000_0144, 12);
			begin
				show(12'h010, 24'h12_3456, 24'h12_3456);
				show(12'h011, 24'h00_0000, 24'h01_0101);
			end
		join
		$display("depth six and blink test done");
		cfg('{44'h014_0000_0000, 44'h40C_0000_0100, 44'h410_0000_0040, 44'h408_0008_0010,
			44'h010_0008_0000, 44'h018_0002_0101});
		for (int k = 0; k < 9; k++) begin
			if (k > 0) begin
				@(posedge pclk);
				frame_start <= 1'b1;
				@(posedge pclk);
				frame_start <= 1'b0;
			end
			repeat (4) @(posedge pclk);
			#1;
			f = (k / 2) % 4;
			`CHK(fetch_addr, 24'(32'h100 + (f / 2) * 32'h200 + (f % 2) * 32'h10))
		end
		$display("loop test done");
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		#1;
		`CHK(fetch_addr, 24'h00_0000)
		`CHK(out_valid, 1'b0)
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h004, 32'h0);
		`CHK(r, 32'h0000_0108)
		apb(1'b0, 12'h420, 32'h0);
		`CHK(r, 32'h0000_0000)
		$display("reset test done");
		end_sim();
	end
endmodule : bowe_top_tb
`default_nettype wire
